// ### lgw_host.sv
module lgw_host (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      sclk,
    output logic      cs_b,
    output logic      din,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        din  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // half = clk cycles per sclk phase; 4 keeps a frame far below wake length
    task automatic xfer(input logic [15:0] cmd, input int half, output logic [15:0] rsp);
        wait_clk(1);
        cs_b = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din = cmd[i];
            wait_clk(half);
            sclk   = 1'b1;
            rsp[i] = dout;
            wait_clk(half);
            sclk = 1'b0;
        end
        wait_clk(1);
        cs_b = 1'b1;
        // released line must not look like held data
        din = ~din;
        wait_clk(8);
    endtask

    // chip-select low with sclk standing still
    task automatic hold_low(input int n);
        wait_clk(1);
        cs_b = 1'b0;
        wait_clk(n);
        cs_b = 1'b1;
        wait_clk(8);
    endtask
endmodule

// ### lgw_pkg.sv
package lgw_pkg;

    // clocking and pwm time base
    localparam int          CLK_HZ       = 40_000_000;
    localparam int          OSC_HZ       = 32_000;
    localparam int          OSC_DIV      = CLK_HZ / OSC_HZ;
    localparam logic [10:0] OSC_DIV_LAST = 11'(OSC_DIV - 1);

    // chip-select wakeup: pwm clock periods of low chip-select
    localparam int          WAKE_PERIODS = 256;
    localparam logic [8:0]  WAKE_LAST    = 9'(WAKE_PERIODS - 1);
    localparam logic [8:0]  WAKE_SAT     = 9'(WAKE_PERIODS);

    localparam int          NUM_PORTS    = 10;
    localparam int          FRAME_BITS   = 16;

    // command addresses
    localparam logic [6:0]  A_PORT0      = 7'h00;
    localparam logic [6:0]  A_PORT9      = 7'h09;
    localparam logic [6:0]  A_GRP_ALL    = 7'h0A;
    localparam logic [6:0]  A_GRP_LOW    = 7'h0B;
    localparam logic [6:0]  A_GRP_MID    = 7'h0C;
    localparam logic [6:0]  A_GRP_TOP    = 7'h0D;
    localparam logic [6:0]  A_IN_LOW     = 7'h0E;
    localparam logic [6:0]  A_IN_HIGH    = 7'h0F;
    localparam logic [6:0]  A_CFG        = 7'h10;
    localparam logic [6:0]  A_ISET_LOW   = 7'h13;
    localparam logic [6:0]  A_ISET_HIGH  = 7'h14;
    localparam logic [6:0]  A_NOP        = 7'h20;

    // port output codes
    localparam logic [7:0]  C_LOW        = 8'h00;
    localparam logic [7:0]  C_HIGH       = 8'h01;
    localparam logic [7:0]  C_STATIC     = 8'h02;
    localparam logic [7:0]  C_PWM_MIN    = 8'h03;
    localparam logic [7:0]  C_PWM_MAX    = 8'hFE;
    localparam logic [7:0]  C_OFF        = 8'hFF;

    // configuration bit positions
    localparam int          CFG_RUN      = 0;
    localparam int          CFG_CSWAKE   = 1;
    localparam int          CFG_OSC      = 7;

    // reset values
    localparam logic [7:0]  PORT_RESET   = 8'hFF;
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [9:0]  ISET_RESET   = 10'h000;
    localparam logic [13:0] SYNC_RESET   = 14'h0004;

    typedef struct packed {
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } lgw_frame_t;

endpackage

// ### lgw_port.sv
module lgw_port (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // serial interface
    input  wire logic       sclk,
    input  wire logic       cs_b,
    input  wire logic       din,
    // dual-use data out / pwm clock pin
    input  wire logic       serial_out_or_pwm_clock_in_i,
    output logic            serial_out_or_pwm_clock_in_o,
    output logic            serial_out_or_pwm_clock_in_oe,
    // open-drain io ports
    input  wire logic [9:0] io_ports_i,
    output logic      [9:0] io_ports_o,
    output logic      [9:0] io_ports_oe,
    // current sink control
    output logic      [9:0] sink_en,
    output logic      [9:0] sink_full,
    output logic            pwm_active
);

    // synchronisers: {io ports, sclk, cs_b, din, osc}
    logic [13:0] meta_q;
    logic [13:0] sync_q;
    logic [2:0]  prev_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= lgw_pkg::SYNC_RESET;
            sync_q <= lgw_pkg::SYNC_RESET;
            prev_q <= 3'h2;
        end else begin
            meta_q <= {io_ports_i, sclk, cs_b, din, serial_out_or_pwm_clock_in_i};
            sync_q <= meta_q;
            prev_q <= {sync_q[3], sync_q[2], sync_q[0]};
        end
    end

    logic [9:0] in_s;
    logic       sclk_s;
    logic       cs_s;
    logic       din_s;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic       cs_fall;
    logic       osc_rise;

    assign in_s      = sync_q[13:4];
    assign sclk_s    = sync_q[3];
    assign cs_s      = sync_q[2];
    assign din_s     = sync_q[1];
    assign sclk_rise = sclk_s & ~prev_q[2];
    assign sclk_fall = ~sclk_s & prev_q[2];
    assign cs_rise   = cs_s & ~prev_q[1];
    assign cs_fall   = ~cs_s & prev_q[1];
    assign osc_rise  = sync_q[0] & ~prev_q[0];

    // register state
    logic [9:0][7:0] code_q;
    logic [9:0][7:0] code_d;
    logic [7:0]      cfg_q;
    logic [7:0]      cfg_d;
    logic [9:0]      iset_q;
    logic [9:0]      iset_d;

    // serial shift state
    logic [15:0]     sr_q;
    logic [15:0]     sr_d;
    logic            dout_q;
    logic            dout_d;

    lgw_pkg::lgw_frame_t frame;
    logic                wr;
    logic [7:0]          rd_data;

    assign frame = lgw_pkg::lgw_frame_t'(sr_q);
    assign wr    = cs_rise & ~frame.rd;

    // wakeup and pwm time base
    logic [10:0] div_q;
    logic [10:0] div_d;
    logic [8:0]  wake_cnt_q;
    logic [8:0]  wake_cnt_d;
    logic [7:0]  pwm_cnt_q;
    logic [7:0]  pwm_cnt_d;
    logic        tick;
    logic        wake_hit;
    logic        pwm_run;
    logic        run;

    assign run = cfg_q[lgw_pkg::CFG_RUN];

    // external clock only when the pin is switched to input
    assign tick = cfg_q[lgw_pkg::CFG_OSC] ? osc_rise
                                          : (div_q == lgw_pkg::OSC_DIV_LAST);

    // counting starts on the first tick after the fall, so a hit means
    // 255 to 256 periods of low chip-select; sclk and din are not looked at
    assign wake_hit = ~cs_s & cfg_q[lgw_pkg::CFG_CSWAKE] & tick
                      & (wake_cnt_q == lgw_pkg::WAKE_LAST);

    always_comb begin
        div_d      = (div_q == lgw_pkg::OSC_DIV_LAST) ? 11'h000 : div_q + 11'h001;
        wake_cnt_d = wake_cnt_q;
        if (cs_s || !cfg_q[lgw_pkg::CFG_CSWAKE]) begin
            wake_cnt_d = 9'h000;
        end else if (tick && wake_cnt_q != lgw_pkg::WAKE_SAT) begin
            wake_cnt_d = wake_cnt_q + 9'h001;
        end
        pwm_cnt_d = pwm_cnt_q;
        if (!pwm_run) begin
            pwm_cnt_d = 8'h00;
        end else if (tick) begin
            pwm_cnt_d = pwm_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q      <= 11'h000;
            wake_cnt_q <= 9'h000;
            pwm_cnt_q  <= 8'h00;
        end else begin
            div_q      <= div_d;
            wake_cnt_q <= wake_cnt_d;
            pwm_cnt_q  <= pwm_cnt_d;
        end
    end

    // read data, loaded into the shift register when a read frame closes
    always_comb begin
        rd_data = 8'h00;
        if (frame.addr <= lgw_pkg::A_PORT9) begin
            rd_data = code_q[frame.addr[3:0]];
        end else begin
            unique case (frame.addr)
                lgw_pkg::A_GRP_ALL,
                lgw_pkg::A_GRP_LOW:   rd_data = code_q[0];
                lgw_pkg::A_GRP_MID:   rd_data = code_q[4];
                lgw_pkg::A_GRP_TOP:   rd_data = code_q[8];
                lgw_pkg::A_IN_LOW:    rd_data = in_s[7:0];
                lgw_pkg::A_IN_HIGH:   rd_data = {6'h00, in_s[9:8]};
                lgw_pkg::A_CFG:       rd_data = cfg_q;
                lgw_pkg::A_ISET_LOW:  rd_data = iset_q[7:0];
                lgw_pkg::A_ISET_HIGH: rd_data = {6'h00, iset_q[9:8]};
                default:              rd_data = 8'h00;
            endcase
        end
    end

    always_comb begin
        sr_d   = sr_q;
        dout_d = dout_q;
        if (!cs_s && sclk_rise) begin
            sr_d = {sr_q[14:0], din_s};
        end
        if ((!cs_s && sclk_fall) || cs_fall) begin
            dout_d = sr_q[15];
        end
        if (cs_rise && frame.rd) begin
            sr_d = {sr_q[15:8], rd_data};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_q   <= 16'h0000;
            dout_q <= 1'b0;
        end else begin
            sr_q   <= sr_d;
            dout_q <= dout_d;
        end
    end

    // register writes; a configuration write in the frame overrides a coincident wakeup
    always_comb begin
        code_d = code_q;
        cfg_d  = cfg_q;
        iset_d = iset_q;
        if (wake_hit) begin
            cfg_d[lgw_pkg::CFG_RUN] = 1'b1;
        end
        if (wr) begin
            for (int i = 0; i < lgw_pkg::NUM_PORTS; i++) begin
                if (frame.addr == 7'(i)
                    || frame.addr == lgw_pkg::A_GRP_ALL
                    || (frame.addr == lgw_pkg::A_GRP_LOW && i < 4)
                    || (frame.addr == lgw_pkg::A_GRP_MID && i >= 4 && i < 8)
                    || (frame.addr == lgw_pkg::A_GRP_TOP && i >= 8)) begin
                    code_d[i] = frame.data;
                end
            end
            if (frame.addr == lgw_pkg::A_CFG) begin
                cfg_d = frame.data;
            end
            if (frame.addr == lgw_pkg::A_ISET_LOW) begin
                iset_d[7:0] = frame.data;
            end
            if (frame.addr == lgw_pkg::A_ISET_HIGH) begin
                iset_d[9:8] = frame.data[1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            code_q <= {lgw_pkg::NUM_PORTS{lgw_pkg::PORT_RESET}};
            cfg_q  <= lgw_pkg::CFG_RESET;
            iset_q <= lgw_pkg::ISET_RESET;
        end else begin
            code_q <= code_d;
            cfg_q  <= cfg_d;
            iset_q <= iset_d;
        end
    end

    // port drive
    logic [9:0] oe_d;
    logic [9:0] sink_d;
    logic [9:0] full_d;
    logic [9:0] oe_q;
    logic [9:0] sink_q;
    logic [9:0] full_q;
    logic       pin_oe_q;
    logic       pwm_q;

    always_comb begin
        pwm_run = 1'b0;
        oe_d    = 10'h000;
        sink_d  = 10'h000;
        full_d  = 10'h000;
        for (int i = 0; i < lgw_pkg::NUM_PORTS; i++) begin
            if (code_q[i] >= lgw_pkg::C_PWM_MIN && code_q[i] <= lgw_pkg::C_PWM_MAX) begin
                pwm_run = 1'b1;
            end
            // sinks follow run combinationally into the output register, so leaving shutdown shows at sink_en one clk later
            if (run && code_q[i] >= lgw_pkg::C_STATIC && code_q[i] <= lgw_pkg::C_PWM_MAX) begin
                sink_d[i] = (code_q[i] == lgw_pkg::C_STATIC)
                            || (pwm_cnt_q < code_q[i]);
            end
            oe_d[i]   = (code_q[i] == lgw_pkg::C_LOW) || sink_d[i];
            full_d[i] = sink_d[i] & iset_q[i];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_q     <= 10'h000;
            sink_q   <= 10'h000;
            full_q   <= 10'h000;
            pin_oe_q <= 1'b0;
            pwm_q    <= 1'b0;
        end else begin
            oe_q     <= oe_d;
            sink_q   <= sink_d;
            full_q   <= full_d;
            pin_oe_q <= ~cfg_q[lgw_pkg::CFG_OSC];
            pwm_q    <= pwm_run;
        end
    end

    // open drain: the pin value is always low, only the enable moves
    assign io_ports_o                    = 10'h000;
    assign io_ports_oe                   = oe_q;
    assign sink_en                       = sink_q;
    assign sink_full                     = full_q;
    assign pwm_active                    = pwm_q;
    assign serial_out_or_pwm_clock_in_o  = dout_q;
    assign serial_out_or_pwm_clock_in_oe = pin_oe_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_off_code_releases;
        code_q[0] == lgw_pkg::C_OFF |=> !io_ports_oe[0] && !sink_en[0];
    endproperty
    a_off_code_releases: assert property (p_off_code_releases)
        else $error("code FF port still driven");

    property p_low_code_drives;
        code_q[0] == lgw_pkg::C_LOW |=> io_ports_oe[0] && !sink_en[0];
    endproperty
    a_low_code_drives: assert property (p_low_code_drives)
        else $error("code 00 port not driven low");

    property p_static_sink;
        run && code_q[0] == lgw_pkg::C_STATIC |=> sink_en[0] && io_ports_oe[0];
    endproperty
    a_static_sink: assert property (p_static_sink)
        else $error("static sink not on while running");

    property p_shutdown_sinks_off;
        !run && code_q[0] >= lgw_pkg::C_STATIC && code_q[0] <= lgw_pkg::C_PWM_MAX
        |=> !io_ports_oe[0] && !sink_en[0];
    endproperty
    a_shutdown_sinks_off: assert property (p_shutdown_sinks_off)
        else $error("sink active in shutdown");

    property p_pwm_on_time;
        run && code_q[3] >= lgw_pkg::C_PWM_MIN && code_q[3] <= lgw_pkg::C_PWM_MAX
        |=> sink_en[3] == ($past(pwm_cnt_q) < $past(code_q[3]));
    endproperty
    a_pwm_on_time: assert property (p_pwm_on_time)
        else $error("pwm mirror outside on-time");

    property p_standby_counter_idle;
        !pwm_run |=> pwm_cnt_q == 8'h00 && !pwm_active;
    endproperty
    a_standby_counter_idle: assert property (p_standby_counter_idle)
        else $error("pwm running in standby");

    property p_wake_sets_run;
        wake_hit && !wr |=> run;
    endproperty
    a_wake_sets_run: assert property (p_wake_sets_run)
        else $error("wakeup pulse did not set run");

    property p_run_rise_cause;
        $rose(run) |-> $past(wr) || ($past(wake_hit) && $past(wake_cnt_q) == lgw_pkg::WAKE_LAST);
    endproperty
    a_run_rise_cause: assert property (p_run_rise_cause)
        else $error("run set without write or full wakeup pulse");

    // a wakeup can only hit while chip-select is low, so it always lands
    // before the frame's write, which must then stand as written
    property p_write_beats_wake;
        wr && frame.addr == lgw_pkg::A_CFG
        |=> cfg_q == $past(frame.data);
    endproperty
    a_write_beats_wake: assert property (p_write_beats_wake)
        else $error("frame write lost to wakeup");

    property p_input_read;
        cs_rise && frame.rd && frame.addr == lgw_pkg::A_IN_LOW
        |=> sr_q[7:0] == $past(in_s[7:0]);
    endproperty
    a_input_read: assert property (p_input_read)
        else $error("input status read wrong");

    property p_group_all;
        wr && frame.addr == lgw_pkg::A_GRP_ALL
        |=> code_q[0] == $past(frame.data) && code_q[9] == $past(frame.data);
    endproperty
    a_group_all: assert property (p_group_all)
        else $error("group write missed a port");

    property p_nop_inert;
        wr && frame.addr == lgw_pkg::A_NOP && !wake_hit
        |=> $stable(code_q) && $stable(cfg_q) && $stable(iset_q);
    endproperty
    a_nop_inert: assert property (p_nop_inert)
        else $error("no-op write changed a register");

endmodule

// ### lgw_port_tb.sv
module lgw_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst_b;
    logic        sclk;
    logic        cs_b;
    logic        din;
    logic        osc;
    logic        pin_o;
    logic        pin_oe;
    logic        pin;
    logic [9:0]  ext;
    logic [9:0]  io_o;
    logic [9:0]  oe;
    logic [9:0]  pins;
    logic [9:0]  sk;
    logic [9:0]  skf;
    logic        pa;
    logic [15:0] rsp;
    int          n_fail;
    int          tests_run;

    // pin is pwm clock input whenever the device lets go of it
    assign pin  = pin_oe ? pin_o : osc;
    assign pins = (oe & io_o) | (~oe & ext);

    lgw_port i_lgw_port (
        .clk                          (clk),
        .rst_b                        (rst_b),
        .sclk                         (sclk),
        .cs_b                         (cs_b),
        .din                          (din),
        .serial_out_or_pwm_clock_in_i (pin),
        .serial_out_or_pwm_clock_in_o (pin_o),
        .serial_out_or_pwm_clock_in_oe(pin_oe),
        .io_ports_i                   (pins),
        .io_ports_o                   (io_o),
        .io_ports_oe                  (oe),
        .sink_en                      (sk),
        .sink_full                    (skf),
        .pwm_active                   (pa)
    );

    lgw_host i_lgw_host (
        .clk (clk),
        .sclk(sclk),
        .cs_b(cs_b),
        .din (din),
        .dout(pin)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        osc = 1'b0;
        #37;
        forever #100 osc = ~osc;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_lgw_host.xfer({1'b0, a, d}, 4, rsp);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        i_lgw_host.xfer({1'b1, a, 8'h00}, 4, rsp);
        i_lgw_host.xfer({1'b1, 7'h20, 8'h00}, 4, rsp);
        chk(rsp, {1'b1, a, exp});
    endtask

    // one pwm period is 256 ticks of 8 clk, so on-cycles = code * 8
    task automatic duty(input int p, input int code);
        int n;
        n = 0;
        repeat (2048) begin
            @(negedge clk);
            n += int'(sk[p]);
        end
        chk(16'(n), 16'(code * 8));
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial begin
        rst_b     = 1'b0;
        ext       = 10'h3FF;
        n_fail    = 0;
        tests_run = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        chk(16'(oe), 16'h0000);
        chk(16'(sk), 16'h0000);
        chk(16'(pa), 16'h0000);
        for (int i = 0; i < 10; i++) begin
            rd(7'(i), lgw_pkg::PORT_RESET);
        end
        rd(lgw_pkg::A_CFG, lgw_pkg::CFG_RESET);
        $display("test reset done");

        wr(7'h00, lgw_pkg::C_LOW);
        wr(7'h01, lgw_pkg::C_HIGH);
        wr(7'h02, lgw_pkg::C_STATIC);
        chk(16'(pa), 16'h0000);
        wr(7'h03, 8'h80);
        wr(7'h04, lgw_pkg::C_PWM_MIN);
        wr(7'h05, lgw_pkg::C_PWM_MAX);
        wr(lgw_pkg::A_ISET_LOW, 8'h04);
        chk(16'(oe), 16'h0001);
        chk(16'(sk), 16'h0000);
        chk(16'(pa), 16'h0001);
        chk(16'(pins), 16'h03FE);
        rd(7'h03, 8'h80);
        $display("test shutdown setup done");

        wr(lgw_pkg::A_CFG, 8'h81);
        chk(16'(sk[2:0]), 16'h0004);
        chk(16'(skf), 16'h0004);
        repeat (100) @(negedge clk);
        duty(3, 8'h80);
        duty(4, 3);
        duty(5, 254);
        $display("test pwm done");

        wr(lgw_pkg::A_CFG, 8'h80);
        chk(16'(sk), 16'h0000);
        wr(7'h02, lgw_pkg::C_LOW);
        chk(16'(oe), 16'h0005);
        wr(7'h00, lgw_pkg::C_STATIC);
        chk(16'(oe), 16'h0004);
        $display("test shutdown rewrite done");

        wr(lgw_pkg::A_CFG, 8'h82);
        // a clockless frame replays the stale shift bits, so leave a no-op there
        wr(lgw_pkg::A_NOP, 8'h00);
        i_lgw_host.hold_low(2000);
        chk(16'(sk[0]), 16'h0000);
        i_lgw_host.hold_low(2400);
        chk(16'(sk[0]), 16'h0001);
        wr(lgw_pkg::A_CFG, 8'h82);
        i_lgw_host.xfer({1'b0, 7'h20, 8'h00}, 80, rsp);
        chk(16'(sk[0]), 16'h0001);
        wr(lgw_pkg::A_CFG, 8'h82);
        i_lgw_host.xfer({1'b0, lgw_pkg::A_CFG, 8'h82}, 80, rsp);
        chk(16'(sk[0]), 16'h0000);
        wr(lgw_pkg::A_CFG, 8'h01);
        rd(lgw_pkg::A_CFG, 8'h01);
        rd(7'h00, lgw_pkg::C_STATIC);
        $display("test wakeup done");

        wr(lgw_pkg::A_GRP_LOW, lgw_pkg::C_HIGH);
        wr(lgw_pkg::A_GRP_MID, lgw_pkg::C_LOW);
        wr(lgw_pkg::A_GRP_TOP, lgw_pkg::C_HIGH);
        chk(16'(oe), 16'h00F0);
        chk(16'(sk), 16'h0000);
        chk(16'(pa), 16'h0000);
        rd(7'h09, lgw_pkg::C_HIGH);
        rd(7'h07, lgw_pkg::C_LOW);
        rd(7'h03, lgw_pkg::C_HIGH);
        ext = 10'h2A5;
        rd(lgw_pkg::A_IN_LOW, 8'h05);
        rd(lgw_pkg::A_IN_HIGH, 8'h02);
        wr(lgw_pkg::A_NOP, lgw_pkg::C_LOW);
        rd(7'h00, lgw_pkg::C_HIGH);
        rd(lgw_pkg::A_NOP, 8'h00);
        wr(lgw_pkg::A_GRP_ALL, lgw_pkg::C_OFF);
        chk(16'(oe), 16'h0000);
        rd(7'h05, lgw_pkg::C_OFF);
        $display("test groups and inputs done");
        end_sim();
    end
endmodule
